// ---- upv_pkg.sv ----
// Constants and types of the phase-to-phase undervoltage element
// Assumes a 200 MHz ref_clk and register access over APB
package upv_pkg;
    localparam int NI            = 2;
    localparam int NG            = 2;
    localparam int TW            = 20;
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_NS       = 1000000;
    localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
    localparam int UNIT10_TICKS  = 10;
    localparam int BLK_HOLD_MS   = 20;
    localparam int BLK_HOLD_TICKS = BLK_HOLD_MS * 1000000 / TICK_NS;
    localparam logic [31:0] NOM_CODE = 32'h0000_1000;
    localparam logic [8:0]  LOW_PCT  = 9'h028;
    localparam logic [7:0]  PU_RST   = 8'h5F;
    localparam logic [15:0] TD_RST   = 16'h00C8;
    localparam logic [9:0]  PKD_RST  = 10'h028;
    localparam logic [12:0] DOD_RST  = 13'h0014;
    localparam logic [8:0]  RAT_RST  = 9'h069;
    localparam logic [5:0]  O_CTRL   = 6'h00;
    localparam logic [5:0]  O_PU0    = 6'h04;
    localparam logic [5:0]  O_PU1    = 6'h08;
    localparam logic [5:0]  O_TD0    = 6'h0C;
    localparam logic [5:0]  O_TD1    = 6'h10;
    localparam logic [5:0]  O_PKD    = 6'h14;
    localparam logic [5:0]  O_DOD    = 6'h18;
    localparam logic [5:0]  O_RAT    = 6'h1C;
    localparam logic [5:0]  O_CNT    = 6'h20;
    localparam logic [5:0]  O_STAT   = 6'h34;
    localparam logic [5:0]  G_BLK    = 6'h04;
    localparam logic [5:0]  G_GRP    = 6'h00;
    localparam logic [5:0]  G_IST    = 6'h04;
    localparam logic [5:0]  G_ICLR   = 6'h08;
    localparam logic [5:0]  G_IEN    = 6'h0C;
    localparam int C_EN  = 0;
    localparam int C_BLK = 1;
    localparam int C_OP  = 3;

    typedef struct packed {
        logic                 en;
        logic [1:0]           blk_src;
        logic [NG-1:0]        op;
        logic [NG-1:0][7:0]   pu;
        logic [NG-1:0][15:0]  tdly;
        logic [9:0]           pkdly;
        logic [12:0]          dodly;
        logic [8:0]           ratio;
    } upv_set_type;

    typedef struct packed {
        logic                 pick;
        logic                 tripd;
        logic                 blk;
        logic [TW-1:0]        pk_tmr;
        logic [TW-1:0]        do_tmr;
        logic [TW-1:0]        tr_tmr;
        logic [TW-1:0]        bh_tmr;
        logic [4:0][15:0]     cnt;
    } upv_inst_type;

    typedef struct packed {
        upv_set_type [NI-1:0]  set;
        upv_inst_type [NI-1:0] inst;
        logic                  grp;
        logic [17:0]           tick_cnt;
        logic                  tick;
        logic [2*NI-1:0]       ist;
        logic [2*NI-1:0]       ien;
        logic                  irq;
        logic [NI-1:0]         pick_o;
        logic [NI-1:0]         trip_o;
        logic                  pready;
        logic                  pslverr;
        logic [31:0]           prdata;
    } upv_state_type;

    localparam upv_set_type SET_RST = {1'b0, 2'h0, {NG{1'b1}},
        {NG{PU_RST}}, {NG{TD_RST}}, PKD_RST, DOD_RST, RAT_RST};
    localparam int REST_W = $bits(upv_state_type) - NI * $bits(upv_set_type);
    localparam upv_state_type ST_RST = {{NI{SET_RST}}, {REST_W{1'b0}}};
endpackage

// ---- upv_top.sv ----
// Phase-to-phase undervoltage element with APB registers and interrupt
// Assumes voltage magnitudes and block inputs synchronous to ref_clk
`timescale 1ns/10ps
module upv_top
    import upv_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
)
(
    input  wire logic                ref_clk,
    input  wire logic                rst_b,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [2:0][15:0]    v_ll,
    input  wire logic [2:0]          user_var,
    input  wire logic                fuse_sup_en,
    input  wire logic                fuse_sup_act,
    output logic      [NI-1:0]       pickup,
    output logic      [NI-1:0]       trip_pulse,
    output logic                     irq
);

    upv_state_type      st_ff;
    upv_state_type      nxt_st;
    upv_set_type        s;
    upv_set_type        ws;
    upv_inst_type       c;
    upv_inst_type       n;
    logic [8:0]         thr;
    logic [2:0]         und;
    logic [2:0]         hld;
    logic [2:0]         low;
    logic               blk_raw;
    logic               g;
    logic               setup;
    logic               acc;
    logic [5:0]         off;
    logic               ii;
    logic [31:0]        rd;
    logic [2*NI-1:0]    ev;
    logic [2*NI-1:0]    clr;

    function automatic logic below(input logic [15:0] v,
                                   input logic [8:0]  pct);
        return (32'(v) * 32'd100) < (32'(pct) * NOM_CODE);
    endfunction

    function automatic logic [TW-1:0] x10(input logic [15:0] d);
        return TW'(d) * TW'(UNIT10_TICKS);
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        if (a[11:6] == G_BLK)
            return a[5:0] <= G_IEN;
        if (a[11:7] != 5'h00)
            return 1'b0;
        return a[5:0] <= O_STAT;
    endfunction

    always_comb
    begin
        nxt_st = st_ff;
        // Millisecond tick
        nxt_st.tick = st_ff.tick_cnt == 18'(TICK_CYCLES - 1);
        nxt_st.tick_cnt = nxt_st.tick ? 18'h00000
                                      : st_ff.tick_cnt + 18'h00001;
        ev = '0;
        s = st_ff.set[0];
        c = st_ff.inst[0];
        n = c;
        g = st_ff.grp;
        thr = '0;
        und = '0;
        hld = '0;
        low = '0;
        blk_raw = 1'b0;
        for (int i = 0; i < NI; i++)
        begin
            s = st_ff.set[i];
            c = st_ff.inst[i];
            n = c;
            thr = {1'b0, s.pu[g]};
            for (int p = 0; p < 3; p++)
            begin
                und[p] = below(v_ll[p], thr);
                low[p] = below(v_ll[p], LOW_PCT);
                hld[p] = (32'(v_ll[p]) * 32'd10000)
                       < (32'(thr) * 32'(s.ratio) * NOM_CODE);
            end
            blk_raw = (|low) | (fuse_sup_en & fuse_sup_act)
                    | (s.blk_src != 2'h0
                       && user_var[s.blk_src - 2'h1]);
            // Block stays for a hold time once every cause clears
            n.blk = blk_raw
                  | (c.blk && c.bh_tmr < TW'(BLK_HOLD_TICKS));
            n.bh_tmr = blk_raw ? '0
                     : c.bh_tmr + TW'(c.blk & st_ff.tick);
            nxt_st.trip_o[i] = 1'b0;
            if (!(s.en && s.op[g]) || n.blk)
            begin
                n.pick = 1'b0;
                n.tripd = 1'b0;
                n.pk_tmr = '0;
                n.do_tmr = '0;
                n.tr_tmr = '0;
            end
            else if (!c.pick)
            begin
                n.do_tmr = '0;
                n.tr_tmr = '0;
                n.tripd = 1'b0;
                if (!(|und))
                    n.pk_tmr = '0;
                else if (c.pk_tmr >= TW'(s.pkdly))
                begin
                    n.pick = 1'b1;
                    n.pk_tmr = '0;
                    n.cnt[0] = c.cnt[0] + 16'h0001;
                    for (int p = 0; p < 3; p++)
                        n.cnt[2+p] = c.cnt[2+p] + 16'(und[p]);
                    ev[2*i] = 1'b1;
                end
                else
                    n.pk_tmr = c.pk_tmr + TW'(st_ff.tick);
            end
            else
            begin
                if (|hld)
                    n.do_tmr = '0;
                else if (c.do_tmr >= x10(16'(s.dodly)))
                begin
                    n.pick = 1'b0;
                    n.tripd = 1'b0;
                    n.do_tmr = '0;
                    n.tr_tmr = '0;
                end
                else
                    n.do_tmr = c.do_tmr + TW'(st_ff.tick);
                if (n.pick && !c.tripd)
                begin
                    if (c.tr_tmr >= x10(s.tdly[g]))
                    begin
                        n.tripd = 1'b1;
                        nxt_st.trip_o[i] = 1'b1;
                        n.cnt[1] = c.cnt[1] + 16'h0001;
                        ev[2*i+1] = 1'b1;
                    end
                    else
                        n.tr_tmr = c.tr_tmr + TW'(st_ff.tick);
                end
            end
            nxt_st.pick_o[i] = n.pick;
            nxt_st.inst[i] = n;
        end

        // APB slave: answer prepared in setup, taken in access
        setup = psel & ~penable;
        acc = psel & penable & st_ff.pready;
        off = paddr[5:0];
        ii = paddr[6];
        ws = st_ff.set[ii];
        c = st_ff.inst[ii];
        rd = '0;
        if (paddr[11:6] == G_BLK)
        begin
            case (off)
                G_GRP:   rd = 32'(st_ff.grp);
                G_IST:   rd = 32'(st_ff.ist);
                G_IEN:   rd = 32'(st_ff.ien);
                default: rd = '0;
            endcase
        end
        else if (mapped(paddr))
        begin
            case (off)
                O_CTRL:  rd = 32'({ws.op, ws.blk_src, ws.en});
                O_PU0:   rd = 32'(ws.pu[0]);
                O_PU1:   rd = 32'(ws.pu[1]);
                O_TD0:   rd = 32'(ws.tdly[0]);
                O_TD1:   rd = 32'(ws.tdly[1]);
                O_PKD:   rd = 32'(ws.pkdly);
                O_DOD:   rd = 32'(ws.dodly);
                O_RAT:   rd = 32'(ws.ratio);
                O_STAT:  rd = 32'({c.blk, c.tripd, c.pick});
                default:
                begin
                    if (off >= O_CNT && off < O_STAT)
                        rd = 32'(c.cnt[off[4:2]]);
                end
            endcase
        end
        nxt_st.pready = setup;
        nxt_st.pslverr = setup & ~mapped(paddr);
        nxt_st.prdata = setup ? rd : st_ff.prdata;

        clr = '0;
        if (acc && pwrite && mapped(paddr))
        begin
            if (paddr[11:6] == G_BLK)
            begin
                case (off)
                    G_GRP:   nxt_st.grp = pwdata[0];
                    G_ICLR:  clr = pwdata[2*NI-1:0];
                    G_IEN:   nxt_st.ien = pwdata[2*NI-1:0];
                    default: clr = '0;
                endcase
            end
            else
            begin
                case (off)
                    O_CTRL:
                    begin
                        ws.en = pwdata[C_EN];
                        ws.blk_src = pwdata[C_BLK +: 2];
                        ws.op = pwdata[C_OP +: NG];
                    end
                    O_PU0:   ws.pu[0] = pwdata[7:0];
                    O_PU1:   ws.pu[1] = pwdata[7:0];
                    O_TD0:   ws.tdly[0] = pwdata[15:0];
                    O_TD1:   ws.tdly[1] = pwdata[15:0];
                    O_PKD:   ws.pkdly = pwdata[9:0];
                    O_DOD:   ws.dodly = pwdata[12:0];
                    O_RAT:   ws.ratio = pwdata[8:0];
                    default: ws = st_ff.set[ii];
                endcase
                nxt_st.set[ii] = ws;
            end
        end
        // Sticky events; a new event wins over a clear
        nxt_st.ist = (st_ff.ist & ~clr) | ev;
        nxt_st.irq = |(nxt_st.ist & nxt_st.ien);
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            st_ff <= ST_RST;
        else
            st_ff <= nxt_st;
    end

    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign pickup = st_ff.pick_o;
    assign trip_pulse = st_ff.trip_o;
    assign irq = st_ff.irq;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    property p_off;
        !st_ff.set[0].en |=> !pickup[0];
    endproperty
    a_off: assert property (p_off)
        else $error("Pickup while disabled");

    property p_mode;
        !st_ff.set[0].op[st_ff.grp] |=> !pickup[0];
    endproperty
    a_mode: assert property (p_mode)
        else $error("Pickup while operate mode off");

    property p_inst;
        !st_ff.set[1].en |=> !pickup[1] && !trip_pulse[1];
    endproperty
    a_inst: assert property (p_inst)
        else $error("Second instance acted while disabled");

    property p_ublk;
        st_ff.set[0].blk_src == 2'h1 && user_var[0] |=> !pickup[0];
    endproperty
    a_ublk: assert property (p_ublk)
        else $error("Pickup despite user block");

    property p_fuse;
        fuse_sup_en && fuse_sup_act |=> !pickup[0];
    endproperty
    a_fuse: assert property (p_fuse)
        else $error("Pickup despite fuse failure");

    property p_low;
        below(v_ll[0], LOW_PCT) |=> !pickup[0];
    endproperty
    a_low: assert property (p_low)
        else $error("Pickup below forty percent");

    sequence s_fuse_drop;
        (fuse_sup_en && fuse_sup_act) ##1 !(fuse_sup_en && fuse_sup_act);
    endsequence
    property p_hold;
        s_fuse_drop |=> !pickup[0] [*2];
    endproperty
    a_hold: assert property (p_hold)
        else $error("Block released without hold");

    property p_pulse;
        trip_pulse[0] |=> !trip_pulse[0];
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("Trip longer than one cycle");

    property p_tcnt;
        trip_pulse[0] |-> st_ff.inst[0].cnt[1]
            == $past(st_ff.inst[0].cnt[1]) + 16'h0001;
    endproperty
    a_tcnt: assert property (p_tcnt)
        else $error("Trip counter not advanced");

    property p_pcnt;
        $rose(pickup[0]) |-> st_ff.inst[0].cnt[0]
            == $past(st_ff.inst[0].cnt[0]) + 16'h0001;
    endproperty
    a_pcnt: assert property (p_pcnt)
        else $error("Pickup counter not advanced");

    property p_trip_pick;
        trip_pulse[0] |-> pickup[0] && $past(pickup[0]);
    endproperty
    a_trip_pick: assert property (p_trip_pick)
        else $error("Trip without held pickup");

    property p_tmr;
        !pickup[0] |-> st_ff.inst[0].tr_tmr == '0;
    endproperty
    a_tmr: assert property (p_tmr)
        else $error("Trip timer ran without pickup");
endmodule

// ---- upv_vfe.sv ----
// Voltage front end model: line-to-line magnitudes for the element
// Assumes ref_clk domain; one cycle of measurement latency
`timescale 1ns/10ps
module upv_vfe
    import upv_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic [2:0][15:0] lvl,
    output logic      [2:0][15:0] v_ll
);
    // Nominal magnitudes out of reset, then the commanded levels
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            v_ll <= {3{NOM_CODE[15:0]}};
        else
            v_ll <= lvl;
    end
endmodule

// ---- tb_top.sv ----
// Self-checking bench of the undervoltage element over APB
// Assumes upv_pkg, upv_top and upv_vfe compiled before it
`timescale 1ns/10ps
`define CHK(a, b) \
    begin \
        compares++; \
        if ((a) !== (b)) \
            $display("unexpected %0t got %h exp %h", $time, a, b); \
        if ((a) !== (b)) \
            bad_count++; \
    end
module tb_top
    import upv_pkg::*;
;
    logic             ref_clk = 1'b0, rst_b = 1'b0;
    logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]      paddr = 12'h000;
    logic [31:0]      pwdata = 32'h0, prdata, rd;
    logic             pready, pslverr, irq, er;
    logic [2:0][15:0] lvl = {3{16'h1000}}, v_ll;
    logic [2:0]       user_var = 3'h0;
    logic             fs_en = 1'b0, fs_act = 1'b0;
    logic [NI-1:0]    pickup, trip_pulse;
    int               bad_count = 0, compares = 0, n;
    int               seed = 32'h6544BC31;
    int               e[5] = '{0, 0, 0, 0, 0};

    always #2.5 ref_clk = ~ref_clk;

    upv_vfe fe (.ref_clk(ref_clk), .rst_b(rst_b), .lvl(lvl), .v_ll(v_ll));
    upv_top #(.TICK_CYCLES(10)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .v_ll(v_ll), .user_var(user_var),
        .fuse_sup_en(fs_en), .fuse_sup_act(fs_act), .pickup(pickup),
        .trip_pulse(trip_pulse), .irq(irq));

    task automatic end_sim();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic fail();
        bad_count++;
        end_sim();
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (k = 0; k < 40 && pready !== 1'b1; k++)
            @(posedge ref_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
            fail();
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(rd, x)
    endtask

    // Bounded wait for pickup (t=0) or trip pulse (t=1) of instance 0
    task automatic ws(input logic t, input logic v, input int lim);
        for (n = 0; (t ? trip_pulse[0] : pickup[0]) !== v; n++)
        begin
            if (n > lim)
                fail();
            @(posedge ref_clk);
        end
    endtask

    // Counts cycles in which pickup differs from v
    task automatic hold(input logic v, input int c);
        n = 0;
        repeat (c)
            @(posedge ref_clk) n += int'(pickup[0] !== v);
    endtask

    // Model of the event counters: total, trip, three phase pairs
    task automatic pk(input int m);
        e[0]++;
        for (int j = 0; j < 3; j++)
            e[j + 2] += m[j];
    endtask

    task automatic rdcnt();
        for (int j = 0; j < 5; j++)
            rdc({6'h00, O_CNT} + 12'(4 * j), 32'(e[j]));
    endtask

    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        rdc({6'h00, O_CTRL}, 32'h00000018);
        rdc({6'h00, O_PU1}, 32'h0000005F);
        rdc({6'h00, O_TD1}, 32'h000000C8);
        rdc({6'h00, O_PKD}, 32'h00000028);
        rdc({6'h00, O_DOD}, 32'h00000014);
        rdc({6'h00, O_RAT}, 32'h00000069);
        apb(1'b0, 12'h200, 32'h0);
        `CHK(er, 1'b1)
        lvl[0] <= 16'h0700 + 16'($random(seed) & 32'h7FF);
        hold(1'b0, 500);
        `CHK(n, 0)
        apb(1'b1, {6'h00, O_PKD}, 32'h0);
        apb(1'b1, {6'h00, O_TD0}, 32'h1);
        apb(1'b1, {6'h00, O_DOD}, 32'h1);
        apb(1'b1, {6'h04, G_IEN}, 32'hF);
        apb(1'b1, {6'h00, O_CTRL}, 32'h19);
        ws(1'b0, 1'b1, 20);
        pk(1);
        ws(1'b1, 1'b1, 130);
        `CHK(n > 85, 1'b1)
        e[1]++;
        @(posedge ref_clk);
        `CHK(trip_pulse[0], 1'b0)
        rdc({6'h04, G_IST}, 32'h3);
        apb(1'b1, {6'h04, G_IEN}, 32'h0);
        repeat (2) @(posedge ref_clk);
        `CHK(irq, 1'b0)
        apb(1'b1, {6'h04, G_IEN}, 32'hF);
        repeat (2) @(posedge ref_clk);
        `CHK(irq, 1'b1)
        apb(1'b1, {6'h04, G_ICLR}, 32'h3);
        rdc({6'h04, G_IST}, 32'h0);
        `CHK(irq, 1'b0)
        lvl[0] <= 16'h0FE0;
        hold(1'b1, 300);
        `CHK(n, 0)
        lvl[0] <= 16'h1000;
        hold(1'b1, 80);
        `CHK(n, 0)
        ws(1'b0, 1'b0, 60);
        apb(1'b1, {6'h00, O_TD0}, 32'h64);
        apb(1'b1, {6'h00, O_PKD}, 32'h5);
        lvl <= {16'h0F00, 16'h0F00, 16'h1000};
        hold(1'b0, 20);
        lvl <= {3{16'h1000}};
        hold(1'b0, 80);
        `CHK(n, 0)
        lvl <= {16'h0F00, 16'h0F00, 16'h1000};
        ws(1'b0, 1'b1, 80);
        `CHK(n > 38, 1'b1)
        pk(6);
        lvl <= {3{16'h1000}};
        ws(1'b0, 1'b0, 150);
        rdcnt();
        apb(1'b1, {6'h00, O_CTRL}, 32'h1D);
        for (int k = 0; k < 3; k++)
        begin
            user_var <= (k == 0) ? 3'h2 : 3'h5;
            fs_en <= (k == 1);
            fs_act <= (k > 0);
            lvl[0] <= (k == 2) ? 16'h0500 : 16'h0F00;
            hold(1'b0, 100);
            `CHK(n, 0)
            user_var <= 3'h5;
            fs_en <= 1'b0;
            lvl[0] <= 16'h0F00;
            hold(1'b0, 150);
            `CHK(n, 0)
            ws(1'b0, 1'b1, 130);
            pk(1);
            lvl[0] <= 16'h1000;
            ws(1'b0, 1'b0, 150);
        end
        apb(1'b1, {6'h00, O_CTRL}, 32'h11);
        lvl[0] <= 16'h0F00;
        hold(1'b0, 100);
        `CHK(n, 0)
        apb(1'b1, {6'h04, G_GRP}, 32'h1);
        ws(1'b0, 1'b1, 80);
        pk(1);
        lvl[0] <= 16'h1000;
        ws(1'b0, 1'b0, 150);
        rdcnt();
        rdc({6'h01, O_CNT}, 32'h0);
        `CHK(pickup[1], 1'b0)
        end_sim();
    end
endmodule
